// ==== fac_pkg.sv ====
// Constants, types and helpers shared by the flash array controller
// Operation
// - Control register FE08: hv, mass, erase, program
// - FE0D to FE0F reserved for array test
// - User array 4096 or 1536 bytes, 48 vector bytes
// - Erase works on whole 64-byte pages
// - One program pass covers one 32-byte row
// - User EE00/F800 to FDFF, vectors FFD0-FFFF
// - Erased bits read one, programmed bits zero
// - Security blocks external viewing of array
// - Vector slots in fixed priority, high byte even
// - Program and erase select never both set
// - High voltage only after select and sequence
// - Block protect guards boundary up to FFFF
// - Mass erase needs block protect all ones
package fac_pkg;
	localparam logic [15:0] FAC_CTRL_IDX  = 16'hfe08;
	localparam logic [15:0] FAC_TEST_LO   = 16'hfe0d;
	localparam logic [15:0] FAC_TEST_HI   = 16'hfe0f;
	localparam logic [15:0] FAC_BPR_IDX   = 16'hffbe;
	localparam logic [15:0] FAC_TRIM5_IDX = 16'hffc0;
	localparam logic [15:0] FAC_TRIM3_IDX = 16'hffc1;
	localparam logic [15:0] FAC_VEC_LO    = 16'hffd0;
	localparam logic [15:0] FAC_USER_END  = 16'hfdff;
	localparam logic [15:0] FAC_ARR_BASE  = 16'hee00;
	localparam logic [15:0] FAC_ARR_TOP   = 16'hffff;
	localparam int          FAC_USER_TOP  = 'hfe00;
	localparam int          FAC_USER_MAX  = 4096;
	localparam int          FAC_VEC_BYTES = 48;
	localparam int          FAC_ARR_DEPTH = 'h10000 - 'hee00;
	localparam int          FAC_AIDX_W    = 13;
	// Vector slots, lowest to highest priority; high byte at the even address
	localparam logic [15:0] FAC_VEC_ADC   = 16'hffde;
	localparam logic [15:0] FAC_VEC_KBD   = 16'hffe0;
	localparam logic [15:0] FAC_VEC_TOVF  = 16'hfff2;
	localparam logic [15:0] FAC_VEC_TCH1  = 16'hfff4;
	localparam logic [15:0] FAC_VEC_TCH0  = 16'hfff6;
	localparam logic [15:0] FAC_VEC_IRQ   = 16'hfffa;
	localparam logic [15:0] FAC_VEC_SWI   = 16'hfffc;
	localparam logic [15:0] FAC_VEC_RST   = 16'hfffe;
	// Control register fields
	localparam int          FAC_HV_B      = 3;
	localparam int          FAC_MASS_B    = 2;
	localparam int          FAC_ERASE_B   = 1;
	localparam int          FAC_PROG_B    = 0;
	localparam logic [7:0]  FAC_CTRL_RST  = 8'h00;
	localparam logic [7:0]  FAC_ERASED    = 8'hff;
	localparam logic [7:0]  FAC_BPR_NONE  = 8'hff;
	localparam logic [1:0]  FAC_PROT_HI   = 2'h3;
	localparam logic [5:0]  FAC_PROT_LO   = 6'h00;
	localparam int          FAC_PAGE_BYTES = 64;
	localparam int          FAC_ROW_BYTES  = 32;
	localparam logic [15:0] FAC_PAGE_OFS  = 16'(FAC_PAGE_BYTES - 1);
	localparam logic [15:0] FAC_ROW_OFS   = 16'(FAC_ROW_BYTES - 1);

	typedef enum logic [1:0] {FAC_S_IDLE, FAC_S_SEL, FAC_S_BPR, FAC_S_LATCH} fac_seq_t;

	// Array index of a bus address
	function automatic logic [FAC_AIDX_W-1:0] fac_aidx(input logic [15:0] a);
		logic [15:0] d;
		d = a - FAC_ARR_BASE;
		return d[FAC_AIDX_W-1:0];
	endfunction

	// Boundary chosen by the protect byte; all ones guards nothing
	function automatic logic fac_prot(input logic [7:0] bpr, input logic [15:0] a);
		return (bpr != FAC_BPR_NONE) && (a >= {FAC_PROT_HI, bpr, FAC_PROT_LO});
	endfunction
endpackage

// ==== fac_seq.sv ====
// Access sequence tracker that arms the high-voltage step
`timescale 1ns/1ps
module fac_seq
	import fac_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        sel,
	input  wire logic        bpr_read,
	input  wire logic        arr_write,
	input  wire logic [15:0] wr_addr,
	output logic             armed,
	output logic [15:0]      latch_addr
);
	fac_seq_t    state_r, state_nxt;
	logic [15:0] addr_r, addr_nxt;

	// Select, then protect read, then a latching write; dropping select restarts
	always_comb begin
		state_nxt = state_r;
		addr_nxt  = addr_r;
		if (!sel) begin
			state_nxt = FAC_S_IDLE;
		end else begin
			unique case (state_r)
				FAC_S_IDLE:  state_nxt = FAC_S_SEL;
				FAC_S_SEL:   if (bpr_read) state_nxt = FAC_S_BPR;
				FAC_S_BPR:   if (arr_write) begin
					state_nxt = FAC_S_LATCH;
					addr_nxt  = wr_addr;
				end
				FAC_S_LATCH: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= FAC_S_IDLE;
			addr_r  <= '0;
		end else begin
			state_r <= state_nxt;
			addr_r  <= addr_nxt;
		end
	end

	assign armed      = (state_r == FAC_S_LATCH);
	assign latch_addr = addr_r;
endmodule

// ==== fac_array.sv ====
// Byte array with program port and a one-byte-per-cycle erase sweeper
`timescale 1ns/1ps
module fac_array
	import fac_pkg::*;
#(
	parameter int DEPTH = FAC_ARR_DEPTH
)(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic [FAC_AIDX_W-1:0] rd_idx,
	output logic [7:0]                 rd_data,
	input  wire logic                  pg_en,
	input  wire logic [FAC_AIDX_W-1:0] pg_idx,
	input  wire logic [7:0]            pg_data,
	input  wire logic                  er_start,
	input  wire logic [FAC_AIDX_W-1:0] er_first,
	input  wire logic [FAC_AIDX_W-1:0] er_last,
	output logic                       busy,
	output logic [7:0]                 bpr,
	output logic [15:0]                vec_word
);
	// Ships blank; no reset touches it, so protect and trim bytes persist
	logic [7:0] mem [DEPTH] = '{default: FAC_ERASED};

	logic                  busy_r, busy_nxt;
	logic [FAC_AIDX_W-1:0] cnt_r, cnt_nxt, last_r, last_nxt;

	// Sweep counter; a new start is ignored while a sweep runs
	always_comb begin
		busy_nxt = busy_r;
		cnt_nxt  = cnt_r;
		last_nxt = last_r;
		if (busy_r) begin
			cnt_nxt = cnt_r + 1'b1;
			if (cnt_r == last_r) busy_nxt = 1'b0;
		end else if (er_start) begin
			busy_nxt = 1'b1;
			cnt_nxt  = er_first;
			last_nxt = er_last;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
			cnt_r  <= '0;
			last_r <= '0;
		end else begin
			busy_r <= busy_nxt;
			cnt_r  <= cnt_nxt;
			last_r <= last_nxt;
		end
	end

	// Erase sets bits to one, programming can only clear them
	always_ff @(posedge clk) begin
		if (busy_r) begin
			mem[cnt_r] <= FAC_ERASED;
		end else if (pg_en) begin
			mem[pg_idx] <= mem[pg_idx] & pg_data;
		end
	end

	assign rd_data  = mem[rd_idx];
	assign busy     = busy_r;
	assign bpr      = mem[fac_aidx(FAC_BPR_IDX)];
	assign vec_word = {mem[fac_aidx(FAC_VEC_RST)], mem[fac_aidx(FAC_ARR_TOP)]};
endmodule

// ==== fac_top.sv ====
// APB front end, control register and decode of the program store
`timescale 1ns/1ps
module fac_top
	import fac_pkg::*;
#(
	parameter int USER_BYTES = FAC_USER_MAX
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [17:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ext_view,
	output logic             hv_active,
	output logic [15:0]      reset_vector
);
	// Lowest user address of this variant
	localparam logic [15:0] UBASE = 16'(FAC_USER_TOP - USER_BYTES);
	localparam logic [FAC_AIDX_W-1:0] PAGE_SPAN = FAC_AIDX_W'(FAC_PAGE_BYTES - 1);

	logic [15:0]           idx;
	logic                  aligned, is_ctrl, is_test, is_arr, hit;
	logic                  acc, wr, rd;
	logic [7:0]            ctrl_r, ctrl_nxt;
	logic [31:0]           prdata_r, prdata_nxt;
	logic [15:0]           rvec_r;
	logic [7:0]            arr_rd, bpr;
	logic [15:0]           vec_word;
	logic                  er_busy, er_start, pg_en;
	logic [FAC_AIDX_W-1:0] er_first, er_last;
	logic                  armed, sel, hv, prot_l, same_row;
	logic [15:0]           latch_addr, pg_base;
	logic [1:0]            pe_new;
	logic                  hv_ok, hv_new;

	// Word index on the bus; each byte register owns one aligned word
	assign idx     = paddr[17:2];
	assign aligned = (paddr[1:0] == 2'h0);
	assign is_ctrl = aligned && (idx == FAC_CTRL_IDX);
	assign is_test = aligned && (idx >= FAC_TEST_LO) && (idx <= FAC_TEST_HI);
	// User space per variant, then protect, trim and vector bytes
	assign is_arr  = aligned && (((idx >= UBASE) && (idx <= FAC_USER_END))
	                 || (idx >= FAC_BPR_IDX));
	assign hit     = is_ctrl || is_test || is_arr;

	// Handshake: waits only while an erase sweep owns the array
	assign pready  = !er_busy;
	assign pslverr = psel && penable && !hit;
	assign acc     = psel && penable && pready;
	assign wr      = acc && pwrite && pstrb[0];
	assign rd      = acc && !pwrite;

	assign sel = ctrl_r[FAC_PROG_B] || ctrl_r[FAC_ERASE_B];
	assign hv  = ctrl_r[FAC_HV_B];

	// Sequence tracker: select, protect read, latching write
	fac_seq u_seq (
		.clk        (pclk),
		.rst_n      (presetn),
		.sel        (sel),
		.bpr_read   (rd && aligned && (idx == FAC_BPR_IDX)),
		.arr_write  (wr && is_arr && !hv),
		.wr_addr    (idx),
		.armed      (armed),
		.latch_addr (latch_addr)
	);

	fac_array u_arr (
		.clk      (pclk),
		.rst_n    (presetn),
		.rd_idx   (fac_aidx(idx)),
		.rd_data  (arr_rd),
		.pg_en    (pg_en),
		.pg_idx   (fac_aidx(idx)),
		.pg_data  (pwdata[7:0]),
		.er_start (er_start),
		.er_first (er_first),
		.er_last  (er_last),
		.busy     (er_busy),
		.bpr      (bpr),
		.vec_word (vec_word)
	);

	// Protection of the latched target decides whether high voltage may rise
	assign prot_l   = fac_prot(bpr, latch_addr);
	assign pg_base  = latch_addr & ~FAC_PAGE_OFS;
	assign same_row = ((idx & ~FAC_ROW_OFS) == (latch_addr & ~FAC_ROW_OFS));

	// Control register: interlock, gated high voltage, erase launch
	always_comb begin
		ctrl_nxt = ctrl_r;
		er_start = 1'b0;
		er_first = fac_aidx(pg_base);
		er_last  = fac_aidx(pg_base | FAC_PAGE_OFS);
		if (ctrl_r[FAC_MASS_B]) begin
			er_first = fac_aidx(UBASE);
			er_last  = fac_aidx(FAC_ARR_TOP);
		end
		// Both selects at once is refused; the old pair stays
		pe_new = pwdata[FAC_ERASE_B:FAC_PROG_B];
		if (&pe_new) pe_new = ctrl_r[FAC_ERASE_B:FAC_PROG_B];
		hv_ok = armed && sel && (pe_new == ctrl_r[FAC_ERASE_B:FAC_PROG_B]);
		if (ctrl_r[FAC_ERASE_B] && ctrl_r[FAC_MASS_B]) begin
			hv_ok = hv_ok && (bpr == FAC_BPR_NONE);
		end else begin
			hv_ok = hv_ok && !prot_l;
		end
		hv_new = pwdata[FAC_HV_B] && (hv || hv_ok);
		if (wr && is_ctrl) begin
			ctrl_nxt = FAC_CTRL_RST; // Upper nibble stays zero
			ctrl_nxt[FAC_HV_B]    = hv_new;
			ctrl_nxt[FAC_MASS_B]  = pwdata[FAC_MASS_B];
			ctrl_nxt[FAC_ERASE_B] = pe_new[1];
			ctrl_nxt[FAC_PROG_B]  = pe_new[0];
			// Erase runs once, on the rise of high voltage
			er_start = hv_new && !hv && ctrl_r[FAC_ERASE_B];
		end
	end

	// Program writes land only in the latched row and outside protection
	assign pg_en = wr && is_arr && hv && ctrl_r[FAC_PROG_B] && armed
	               && same_row && !fac_prot(bpr, idx);

	// Read data is captured while selected so it is steady at the answer
	always_comb begin
		prdata_nxt = prdata_r;
		if (psel && !pwrite) begin
			prdata_nxt = '0; // Test and unmapped read zero
			if (is_ctrl) begin
				prdata_nxt[7:0] = ctrl_r;
			end else if (is_arr && !ext_view) begin
				prdata_nxt[7:0] = arr_rd; // Hidden from outside viewers
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r   <= FAC_CTRL_RST;
			prdata_r <= '0;
			rvec_r   <= '0;
		end else begin
			ctrl_r   <= ctrl_nxt;
			prdata_r <= prdata_nxt;
			rvec_r   <= vec_word;
		end
	end

	assign prdata       = prdata_r;
	assign hv_active    = hv;
	assign reset_vector = rvec_r;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_interlock;
		!(ctrl_r[FAC_PROG_B] && ctrl_r[FAC_ERASE_B]);
	endproperty
	a_interlock: assert property (p_interlock)
		else $error("program and erase selects both set");

	property p_upper_zero;
		(wr && is_ctrl) |=> (ctrl_r[7:4] == 4'h0);
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("control register upper bits not zero");

	sequence s_hv_rise;
		$rose(hv);
	endsequence

	property p_hv_armed;
		s_hv_rise |-> ($past(armed) && $past(sel));
	endproperty
	a_hv_armed: assert property (p_hv_armed)
		else $error("high voltage rose without armed sequence");

	property p_hv_prot;
		(s_hv_rise ##0 !ctrl_r[FAC_MASS_B]) |-> !$past(prot_l);
	endproperty
	a_hv_prot: assert property (p_hv_prot)
		else $error("high voltage rose on protected target");

	property p_mass_inhibit;
		(s_hv_rise ##0 ctrl_r[FAC_MASS_B] ##0 ctrl_r[FAC_ERASE_B])
			|-> ($past(bpr) == FAC_BPR_NONE);
	endproperty
	a_mass_inhibit: assert property (p_mass_inhibit)
		else $error("mass erase started with protection active");

	property p_page_span;
		(er_start && !ctrl_r[FAC_MASS_B]) |-> (er_last - er_first == PAGE_SPAN) ##1 er_busy;
	endproperty
	a_page_span: assert property (p_page_span)
		else $error("page erase span is not one page");

	property p_row;
		pg_en |-> same_row && hv;
	endproperty
	a_row: assert property (p_row)
		else $error("program write outside latched row");

	property p_test_read;
		(rd && is_test) |-> (prdata == 32'h0);
	endproperty
	a_test_read: assert property (p_test_read)
		else $error("test location read not zero");

	property p_test_write;
		(wr && is_test) |=> $stable(ctrl_r);
	endproperty
	a_test_write: assert property (p_test_write)
		else $error("test location write changed control");

	property p_secure;
		(rd && is_arr && ext_view) |-> (prdata == 32'h0);
	endproperty
	a_secure: assert property (p_secure)
		else $error("array visible to external viewer");
endmodule

// ==== fac_cpu_model.sv ====
// CPU-side APB master model that issues single register transfers
`timescale 1ns/1ps
module fac_cpu_model (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [17:0]      paddr,
	output logic [31:0]      pwdata,
	output logic [3:0]       pstrb,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// Bus idle at time zero
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 18'h00000;
		pwdata  = 32'h00000000;
		pstrb   = 4'h0;
	end

	// One transfer; request held until pready is seen high at an edge
	task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h000000, wd};
		pstrb   <= 4'hf;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Released lines show the inverse so stale values cannot pass
		paddr   <= ~{idx, 2'b00};
		pwdata  <= ~{24'h000000, wd};
	endtask
endmodule

// ==== test_fac_top.sv ====
// Self-checking bench for the program store controller
`timescale 1ns/1ps
module test_fac_top;
	import fac_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        ext_view = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, hv_active;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic [15:0] reset_vector;
	logic        err;
	int          bad_count = 0;
	int          tests_run = 0;
	int          cycles = 0;

	fac_top #(.USER_BYTES(4096)) fac_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_view(ext_view),
		.hv_active(hv_active), .reset_vector(reset_vector));
	fac_cpu_model fac_cpu_model_i (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	// 200 MHz clock
	always #2.5 pclk = ~pclk;

	// Hang guard; whole run needs well under this
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 30000) begin
			bad_count++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		fac_cpu_model_i.xfer(1'b1, idx, d, rd, err);
	endtask

	// Read and compare data, and the error response
	task automatic rdc(input logic [15:0] idx, input logic [7:0] exp, input logic eerr);
		fac_cpu_model_i.xfer(1'b0, idx, 8'h00, rd, err);
		chk(rd, {24'h000000, exp});
		chk({31'h0, err}, {31'h0, eerr});
	endtask

	// Select, read protect byte, latch address; caller then sets high voltage
	task automatic arm(input logic [7:0] sel, input logic [15:0] a);
		wr(FAC_CTRL_IDX, sel);
		fac_cpu_model_i.xfer(1'b0, FAC_BPR_IDX, 8'h00, rd, err);
		wr(a, 8'h00);
	endtask

	task automatic prog(input logic [15:0] a, input logic [7:0] d);
		arm(8'h01, a);
		wr(FAC_CTRL_IDX, 8'h09);
		wr(a, d);
		wr(FAC_CTRL_IDX, 8'h01);
		wr(FAC_CTRL_IDX, 8'h00);
	endtask

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rdc(FAC_CTRL_IDX, 8'h00, 1'b0);
		// Both selects at once are refused; stray hv refused too
		wr(FAC_CTRL_IDX, 8'hff);
		rdc(FAC_CTRL_IDX, 8'h04, 1'b0);
		wr(FAC_CTRL_IDX, 8'h01);
		wr(FAC_CTRL_IDX, 8'h03);
		rdc(FAC_CTRL_IDX, 8'h01, 1'b0);
		wr(FAC_CTRL_IDX, 8'h00);
		// Test places, decode edges and erased contents
		wr(FAC_TEST_LO, 8'h5a);
		rdc(FAC_TEST_LO, 8'h00, 1'b0);
		rdc(FAC_TEST_HI, 8'h00, 1'b0);
		rdc(16'hfe09, 8'h00, 1'b1);
		rdc(16'hedff, 8'h00, 1'b1);
		rdc(16'hfe00, 8'h00, 1'b1);
		rdc(FAC_ARR_BASE, 8'hff, 1'b0);
		rdc(FAC_USER_END, 8'hff, 1'b0);
		rdc(FAC_VEC_LO, 8'hff, 1'b0);
		// Row program: only the latched row takes data, bits only clear
		arm(8'h01, FAC_ARR_BASE);
		wr(FAC_CTRL_IDX, 8'h09);
		// The write lands at the edge the task returns on; look one edge later
		@(posedge pclk);
		chk({31'h0, hv_active}, 32'h1);
		wr(16'hee01, 8'h5a);
		wr(16'hee01, 8'hf0);
		wr(16'hee20, 8'h00);
		wr(FAC_CTRL_IDX, 8'h01);
		wr(FAC_CTRL_IDX, 8'h00);
		rdc(16'hee01, 8'h50, 1'b0);
		rdc(16'hee20, 8'hff, 1'b0);
		// Page erase spares the next page
		prog(16'hee41, 8'h00);
		arm(8'h02, 16'hee05);
		wr(FAC_CTRL_IDX, 8'h0a);
		wr(FAC_CTRL_IDX, 8'h02);
		wr(FAC_CTRL_IDX, 8'h00);
		rdc(16'hee01, 8'hff, 1'b0);
		rdc(16'hee3f, 8'hff, 1'b0);
		rdc(16'hee41, 8'h00, 1'b0);
		// Reset vector slot, high byte at the even address
		prog(FAC_VEC_RST, 8'h12);
		prog(16'hffff, 8'h34);
		rdc(FAC_VEC_RST, 8'h12, 1'b0);
		chk({16'h0, reset_vector}, 32'h1234);
		// Protect from ff80 upward; hv and mass erase then refused
		prog(FAC_BPR_IDX, 8'hfe);
		arm(8'h01, FAC_TRIM5_IDX);
		wr(FAC_CTRL_IDX, 8'h09);
		rdc(FAC_CTRL_IDX, 8'h01, 1'b0);
		arm(8'h06, FAC_ARR_BASE);
		wr(FAC_CTRL_IDX, 8'h0e);
		rdc(FAC_CTRL_IDX, 8'h06, 1'b0);
		wr(FAC_CTRL_IDX, 8'h01);
		// Mid-run reset clears control, keeps stored bytes
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc(FAC_CTRL_IDX, 8'h00, 1'b0);
		rdc(FAC_BPR_IDX, 8'hfe, 1'b0);
		rdc(FAC_TRIM5_IDX, 8'hff, 1'b0);
		chk({16'h0, reset_vector}, 32'h1234);
		// External viewer sees nothing of the array
		@(posedge pclk);
		ext_view <= 1'b1;
		rdc(FAC_VEC_RST, 8'h00, 1'b0);
		finish_test();
	end
endmodule
